// file: rtl/bcb_exec.sv
// Execution unit for bit clear and branch-if-negative with field handling
// Functional notes
// - Access bit zero ignores bank pointer
// - Access bit one uses bank pointer
// - Extended set, access bit zero, low operand: indexed literal offset
// - Branch only when negative flag set
// - Offset signed, doubled, added to PC
// - Target is address plus two plus 2n
// - Taken branch takes two cycles
// - Shadow registers used only when select set
// - Table pointer is 21 bits
// - Source index offset is 7 bits
// - Destination index offset is 7 bits
// - Branch operand is signed displacement
`timescale 1ns/1ps
module bcb_exec
  import bcb_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  // Decoded instruction
  input  wire logic                 instr_valid_i,
  input  wire logic                 clear_one_bit_op_i,
  input  wire logic                 branch_if_sign_set_op_i,
  input  wire logic [7:0]           file_addr_i,
  input  wire logic [2:0]           bit_sel_i,
  input  wire logic                 access_bit_i,
  input  wire logic [7:0]           branch_offset_i,
  input  wire logic                 ext_set_i,
  // Bank pointer load
  input  wire logic                 bank_load_i,
  input  wire logic [BANK_W-1:0]    bank_value_i,
  // Fast call/return
  input  wire logic                 fast_save_i,
  input  wire logic                 fast_restore_i,
  input  wire logic                 fast_select_i,
  input  wire logic [7:0]           wreg_i,
  input  wire logic [7:0]           status_i,
  // Status flag and index base
  input  wire logic                 negative_flag_i,
  input  wire logic [ADDR_W-1:0]    fsr2_i,
  // Indexed indirect offsets
  input  wire logic [IDX_OFF_W-1:0] source_index_offset_i,
  input  wire logic [IDX_OFF_W-1:0] dest_index_offset_i,
  // Table pointer load
  input  wire logic                 program_table_pointer_load_i,
  input  wire logic [PROGRAM_TABLE_POINTER_W-1:0]  program_table_pointer_value_i,
  // Data memory
  input  wire logic [7:0]           mem_rdata_i,
  output logic [ADDR_W-1:0]         mem_addr_o,
  output logic                      mem_rd_o,
  output logic                      mem_we_o,
  output logic [7:0]                mem_wdata_o,
  // Program counter and pipeline
  output logic [PC_W-1:0]           pc_o,
  output logic                      pipe_flush_o,
  output logic                      busy_o,
  // Shadow state
  output logic [7:0]                shadow_wreg_o,
  output logic [7:0]                shadow_status_o,
  output logic [BANK_W-1:0]         shadow_bank_o,
  output logic [7:0]                restore_wreg_o,
  output logic [7:0]                restore_status_o,
  output logic                      restore_valid_o,
  // Table pointer and index addresses
  output logic [PROGRAM_TABLE_POINTER_W-1:0]       program_table_pointer_o,
  output logic [ADDR_W-1:0]         src_index_addr_o,
  output logic [ADDR_W-1:0]         dst_index_addr_o,
  output logic                      indexed_mode_o,
  output logic [BANK_W-1:0]         ram_bank_pointer_o
);
  bcb_state_e          state;
  logic [BANK_W-1:0]   ram_bank_pointer;
  logic [PC_W-1:0]     pc;
  logic [PC_W-1:0]     next_pc;
  logic [PC_W-1:0]     branch_disp;
  logic                take_branch;
  logic                do_clear;
  bcb_addr_if          ra ();

  assign ra.file_addr  = file_addr_i;
  assign ra.access_bit = access_bit_i;
  assign ra.ext_set    = ext_set_i;
  assign ra.bank       = ram_bank_pointer;
  assign ra.fsr2       = fsr2_i;

  bcb_addr_resolve bcb_addr_resolve_i
  (
    .ra (ra.resolver)
  );

  assign do_clear    = instr_valid_i && clear_one_bit_op_i && state == BCB_IDLE;
  assign take_branch = instr_valid_i && branch_if_sign_set_op_i
                       && negative_flag_i && state == BCB_IDLE;
  assign branch_disp = {{(PC_W-9){branch_offset_i[7]}}, branch_offset_i, 1'b0};
  assign next_pc     = pc + PC_STEP + branch_disp;

  assign busy_o          = state != BCB_IDLE;
  assign pipe_flush_o    = state == BCB_FLUSH;
  assign mem_addr_o      = ra.phys_addr;
  assign mem_rd_o        = do_clear;
  assign indexed_mode_o  = ra.indexed;
  assign pc_o            = pc;
  assign ram_bank_pointer_o = ram_bank_pointer;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      state <= BCB_IDLE;
    else
    begin
      case (state)
        BCB_IDLE:
          state <= take_branch ? BCB_FLUSH : BCB_IDLE;
        BCB_FLUSH:
          state <= BCB_IDLE;
        default:
          state <= BCB_IDLE;
      endcase
    end
  end

  // Program counter
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      pc <= PC_RESET;
    else if (take_branch)
      pc <= next_pc;
    else if (instr_valid_i && state == BCB_IDLE)
      pc <= pc + PC_STEP;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      mem_we_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
    end
    else
    begin
      mem_we_o    <= 1'b0;
      if (do_clear)
      begin
        mem_we_o    <= 1'b1;
        mem_wdata_o <= mem_rdata_i & ~(8'h01 << bit_sel_i);
      end
    end
  end

  // Bank pointer register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ram_bank_pointer <= BANK_RESET;
    else if (bank_load_i)
      ram_bank_pointer <= bank_value_i;
    else if (fast_restore_i && fast_select_i)
      ram_bank_pointer <= shadow_bank_o;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      shadow_wreg_o    <= 8'h00;
      shadow_status_o  <= 8'h00;
      shadow_bank_o    <= BANK_RESET;
      restore_wreg_o   <= 8'h00;
      restore_status_o <= 8'h00;
      restore_valid_o  <= 1'b0;
    end
    else
    begin
      restore_valid_o <= 1'b0;
      if (fast_save_i && fast_select_i)
      begin
        shadow_wreg_o   <= wreg_i;
        shadow_status_o <= status_i;
        shadow_bank_o   <= ram_bank_pointer;
      end
      if (fast_restore_i && fast_select_i)
      begin
        restore_wreg_o   <= shadow_wreg_o;
        restore_status_o <= shadow_status_o;
        restore_valid_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      program_table_pointer_o <= PROGRAM_TABLE_POINTER_RESET;
    else if (program_table_pointer_load_i)
      program_table_pointer_o <= program_table_pointer_value_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      src_index_addr_o <= 12'h000;
      dst_index_addr_o <= 12'h000;
    end
    else
    begin
      src_index_addr_o <= fsr2_i + {5'h00, source_index_offset_i};
      dst_index_addr_o <= fsr2_i + {5'h00, dest_index_offset_i};
    end
  end

  // Branch lands on target and flushes next cycle
  property p_branch_target;
    @(posedge ref_clk_i) disable iff (reset_i)
    take_branch |=> (pc == $past(next_pc)) && pipe_flush_o;
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("branch target wrong");

  property p_not_taken;
    @(posedge ref_clk_i) disable iff (reset_i)
    (instr_valid_i && branch_if_sign_set_op_i && !negative_flag_i && !busy_o)
      |=> !pipe_flush_o && pc == $past(pc) + PC_STEP;
  endproperty
  a_not_taken: assert property (p_not_taken)
    else $error("untaken branch misbehaved");

  property p_two_cycle;
    @(posedge ref_clk_i) disable iff (reset_i)
    take_branch |=> busy_o ##1 !busy_o;
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("branch not two cycles");

  property p_clear_bit;
    @(posedge ref_clk_i) disable iff (reset_i)
    do_clear |=> mem_we_o && !mem_wdata_o[$past(bit_sel_i)]
      && ((mem_wdata_o | (8'h01 << $past(bit_sel_i)))
          == ($past(mem_rdata_i) | (8'h01 << $past(bit_sel_i))));
  endproperty
  a_clear_bit: assert property (p_clear_bit)
    else $error("bit clear wrong");

  property p_one_write;
    @(posedge ref_clk_i) disable iff (reset_i)
    do_clear |=> mem_we_o ##1 !mem_we_o || $past(do_clear);
  endproperty
  a_one_write: assert property (p_one_write)
    else $error("bit clear write count wrong");

  property p_access_bank;
    @(posedge ref_clk_i) disable iff (reset_i)
    (!access_bit_i && !ext_set_i) |-> mem_addr_o[ADDR_W-1:8] ==
      (file_addr_i[7:5] >= 3'h3 ? ACCESS_HI : 4'h0);
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access bank address wrong");

  property p_banked;
    @(posedge ref_clk_i) disable iff (reset_i)
    access_bit_i |-> mem_addr_o == {ram_bank_pointer, file_addr_i};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address wrong");

  property p_indexed;
    @(posedge ref_clk_i) disable iff (reset_i)
    (!access_bit_i && ext_set_i && file_addr_i <= ILO_LIMIT)
      |-> indexed_mode_o && mem_addr_o == fsr2_i + {4'h0, file_addr_i};
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed literal offset wrong");

  property p_shadow_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
    !(fast_save_i && fast_select_i) |=> $stable(shadow_wreg_o);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("shadow changed without select");

  property p_restore;
    @(posedge ref_clk_i) disable iff (reset_i)
    (fast_restore_i && fast_select_i) |=> restore_valid_o
      && restore_wreg_o == $past(shadow_wreg_o);
  endproperty
  a_restore: assert property (p_restore)
    else $error("shadow restore wrong");
endmodule

// file: rtl/bcb_pkg.sv
// Shared constants and types for the bit-clear and negative-branch executor
package bcb_pkg;
  // Widths
  localparam int unsigned PC_W        = 21;
  localparam int unsigned PROGRAM_TABLE_POINTER_W    = 21;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned IDX_OFF_W   = 7;
  localparam int unsigned BANK_W      = 4;
  // Field positions and values
  localparam logic [7:0]  ILO_LIMIT   = 8'h5f;
  localparam logic [3:0]  ACCESS_HI   = 4'hf;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // Reset values
  localparam logic [PC_W-1:0]     PC_RESET     = 21'h000000;
  localparam logic [BANK_W-1:0]   BANK_RESET   = 4'h0;
  localparam logic [PROGRAM_TABLE_POINTER_W-1:0] PROGRAM_TABLE_POINTER_RESET = 21'h000000;
  // Cycle counts
  localparam int unsigned BRANCH_CYCLES = 2;
  localparam int unsigned CLEAR_CYCLES  = 1;

  typedef enum logic [2:0]
  {
    BCB_IDLE  = 3'b001,
    BCB_EXEC  = 3'b010,
    BCB_FLUSH = 3'b100
  } bcb_state_e;
endpackage

// file: rtl/bcb_addr_if.sv
// Address resolution request/answer bundle
`timescale 1ns/1ps
interface bcb_addr_if;
  import bcb_pkg::*;
  logic [7:0]        file_addr;
  logic              access_bit;
  logic              ext_set;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] fsr2;
  logic [ADDR_W-1:0] phys_addr;
  logic              indexed;
  modport requester (output file_addr, access_bit, ext_set, bank, fsr2,
                     input phys_addr, indexed);
  modport resolver (input file_addr, access_bit, ext_set, bank, fsr2,
                    output phys_addr, indexed);
endinterface

// file: rtl/bcb_addr_resolve.sv
// Data memory address resolver for banked, access and indexed modes
`timescale 1ns/1ps
module bcb_addr_resolve
  import bcb_pkg::*;
(
  bcb_addr_if.resolver ra
);
  always_comb
  begin
    ra.indexed   = 1'b0;
    if (!ra.access_bit && ra.ext_set && ra.file_addr <= ILO_LIMIT)
    begin
      ra.indexed   = 1'b1;
      ra.phys_addr = ra.fsr2 + {4'h0, ra.file_addr};
    end
    else if (!ra.access_bit)
    begin
      ra.phys_addr = (ra.file_addr < ACCESS_SPLIT) ? {4'h0, ra.file_addr}
                                                   : {ACCESS_HI, ra.file_addr};
    end
    else
    begin
      ra.phys_addr = {ra.bank, ra.file_addr};
    end
  end
endmodule

// file: testbench/bcb_exec_tb.sv
// Self-checking bench for the bit-clear and negative-branch executor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module bcb_exec_tb
  import bcb_pkg::*;
;
  logic ref_clk_i = 0, reset_i = 1, instr_valid_i = 0, clear_one_bit_op_i = 0;
  logic branch_if_sign_set_op_i = 0, access_bit_i = 0, ext_set_i = 0, bank_load_i = 0;
  logic fast_save_i = 0, fast_restore_i = 0, fast_select_i = 0, negative_flag_i = 0;
  logic program_table_pointer_load_i = 0;
  logic [7:0] file_addr_i = 0, branch_offset_i = 0, wreg_i = 0, status_i = 0, mem_rdata_i = 0;
  logic [2:0] bit_sel_i = 0;
  logic [BANK_W-1:0] bank_value_i = 0, shadow_bank_o, ram_bank_pointer_o;
  logic [ADDR_W-1:0] fsr2_i = 0, mem_addr_o, src_index_addr_o, dst_index_addr_o;
  logic [IDX_OFF_W-1:0] source_index_offset_i = 0, dest_index_offset_i = 0;
  logic [PROGRAM_TABLE_POINTER_W-1:0] program_table_pointer_value_i = 0, program_table_pointer_o;
  logic mem_rd_o, mem_we_o, pipe_flush_o, busy_o, restore_valid_o, indexed_mode_o;
  logic [7:0] mem_wdata_o, shadow_wreg_o, shadow_status_o, restore_wreg_o, restore_status_o;
  logic [PC_W-1:0] pc_o, exp_pc;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  bcb_exec bcb_exec_i
  (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .instr_valid_i (instr_valid_i),
    .clear_one_bit_op_i (clear_one_bit_op_i), .branch_if_sign_set_op_i (branch_if_sign_set_op_i),
    .file_addr_i (file_addr_i), .bit_sel_i (bit_sel_i), .access_bit_i (access_bit_i),
    .branch_offset_i (branch_offset_i), .ext_set_i (ext_set_i), .bank_load_i (bank_load_i),
    .bank_value_i (bank_value_i), .fast_save_i (fast_save_i), .fast_restore_i (fast_restore_i),
    .fast_select_i (fast_select_i), .wreg_i (wreg_i), .status_i (status_i),
    .negative_flag_i (negative_flag_i), .fsr2_i (fsr2_i),
    .source_index_offset_i (source_index_offset_i), .dest_index_offset_i (dest_index_offset_i),
    .program_table_pointer_load_i (program_table_pointer_load_i), .program_table_pointer_value_i (program_table_pointer_value_i),
    .mem_rdata_i (mem_rdata_i), .mem_addr_o (mem_addr_o), .mem_rd_o (mem_rd_o),
    .mem_we_o (mem_we_o), .mem_wdata_o (mem_wdata_o), .pc_o (pc_o),
    .pipe_flush_o (pipe_flush_o), .busy_o (busy_o), .shadow_wreg_o (shadow_wreg_o),
    .shadow_status_o (shadow_status_o), .shadow_bank_o (shadow_bank_o),
    .restore_wreg_o (restore_wreg_o), .restore_status_o (restore_status_o),
    .restore_valid_o (restore_valid_o), .program_table_pointer_o (program_table_pointer_o),
    .src_index_addr_o (src_index_addr_o), .dst_index_addr_o (dst_index_addr_o),
    .indexed_mode_o (indexed_mode_o), .ram_bank_pointer_o (ram_bank_pointer_o)
  );

  always #20 ref_clk_i = ~ref_clk_i;
  // Ceiling well above the fewer than one hundred cycles the tests need
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One clear: c0 shows address and read, c1 writes back
  task automatic do_clear(input logic [7:0] f, input logic [2:0] b, input logic a, e,
                          input logic [7:0] rd, input logic [ADDR_W-1:0] ea, input logic ei);
    @(posedge ref_clk_i);
    instr_valid_i <= 1; clear_one_bit_op_i <= 1; file_addr_i <= f; bit_sel_i <= b;
    access_bit_i <= a; ext_set_i <= e; mem_rdata_i <= rd;
    @(negedge ref_clk_i);
    `CHK("mem_rd", 1'b1, mem_rd_o)
    `CHK("mem_addr", ea, mem_addr_o)
    `CHK("indexed", ei, indexed_mode_o)
    repeat (CLEAR_CYCLES) @(posedge ref_clk_i);
    instr_valid_i <= 0; clear_one_bit_op_i <= 0;
    exp_pc = exp_pc + PC_STEP;
    @(negedge ref_clk_i);
    `CHK("mem_we", 1'b1, mem_we_o)
    `CHK("wdata", rd & ~(8'h01 << b), mem_wdata_o)
    `CHK("pc_clear", exp_pc, pc_o)
    @(negedge ref_clk_i);
    `CHK("we_drop", 1'b0, mem_we_o)
  endtask

  // Branch; a taken one also offers a clear during the busy cycle
  task automatic do_branch(input logic [7:0] n, input logic neg);
    int disp;
    @(posedge ref_clk_i);
    instr_valid_i <= 1; branch_if_sign_set_op_i <= 1; negative_flag_i <= neg;
    branch_offset_i <= n;
    @(posedge ref_clk_i);
    branch_if_sign_set_op_i <= 0; clear_one_bit_op_i <= neg; instr_valid_i <= neg;
    // Signed offset in words, counted in bytes
    disp = 2 * $signed(n);
    exp_pc = neg ? exp_pc + PC_STEP + PC_W'(disp) : exp_pc + PC_STEP;
    @(negedge ref_clk_i);
    `CHK("pc_branch", exp_pc, pc_o)
    `CHK("busy", neg, busy_o)
    `CHK("flush", neg, pipe_flush_o)
    `CHK("rd_refused", 1'b0, mem_rd_o)
    repeat (BRANCH_CYCLES - 1) @(posedge ref_clk_i);
    instr_valid_i <= 0; clear_one_bit_op_i <= 0;
    @(negedge ref_clk_i);
    `CHK("pc_refused", exp_pc, pc_o)
    `CHK("we_refused", 1'b0, mem_we_o)
    `CHK("busy_end", 1'b0, busy_o)
  endtask

  task automatic test_clears();
    for (int i = 0; i < 8; i++)
      do_clear(8'h20, i[2:0], 1'b0, 1'b0, 8'hff, 12'h020, 1'b0);
    do_clear(8'h80, 3'h7, 1'b0, 1'b0, 8'hc7, 12'hf80, 1'b0);
    @(posedge ref_clk_i);
    bank_load_i <= 1; bank_value_i <= 4'h5;
    @(posedge ref_clk_i);
    bank_load_i <= 0;
    @(negedge ref_clk_i);
    `CHK("bank", 4'h5, ram_bank_pointer_o)
    do_clear(8'h12, 3'h3, 1'b1, 1'b0, 8'h0f, 12'h512, 1'b0);
    do_clear(8'h12, 3'h3, 1'b1, 1'b1, 8'h0f, 12'h512, 1'b0);
    @(posedge ref_clk_i);
    fsr2_i <= 12'h100;
    do_clear(8'h5f, 3'h0, 1'b0, 1'b1, 8'h01, 12'h15f, 1'b1);
    do_clear(8'h60, 3'h6, 1'b0, 1'b1, 8'h40, 12'hf60, 1'b0);
  endtask

  task automatic test_branches();
    do_branch(8'h80, 1'b1);
    do_branch(8'h7f, 1'b1);
    do_branch(8'hfe, 1'b1);
    do_branch(8'h80, 1'b0);
  endtask

  task automatic test_shadow_and_ptrs();
    @(posedge ref_clk_i);
    fast_save_i <= 1; fast_select_i <= 0; wreg_i <= 8'ha5; status_i <= 8'h3c;
    @(posedge ref_clk_i);
    fast_save_i <= 0;
    @(negedge ref_clk_i);
    `CHK("shadow_off", 8'h00, shadow_wreg_o)
    @(posedge ref_clk_i);
    fast_save_i <= 1; fast_select_i <= 1;
    @(posedge ref_clk_i);
    fast_save_i <= 0;
    @(negedge ref_clk_i);
    `CHK("shadow_w", 8'ha5, shadow_wreg_o)
    `CHK("shadow_s", 8'h3c, shadow_status_o)
    `CHK("shadow_b", 4'h5, shadow_bank_o)
    @(posedge ref_clk_i);
    program_table_pointer_load_i <= 1; program_table_pointer_value_i <= 21'h1fffff; fsr2_i <= 12'hff0;
    source_index_offset_i <= 7'h7f; dest_index_offset_i <= 7'h01;
    @(posedge ref_clk_i);
    program_table_pointer_load_i <= 0;
    @(negedge ref_clk_i);
    `CHK("program_table_pointer", 21'h1fffff, program_table_pointer_o)
    `CHK("src_idx", 12'h06f, src_index_addr_o)
    `CHK("dst_idx", 12'hff1, dst_index_addr_o)
    // Restore without select is ignored, then a selected one
    @(posedge ref_clk_i);
    bank_load_i <= 1; bank_value_i <= 4'h9; fast_restore_i <= 1; fast_select_i <= 0;
    @(posedge ref_clk_i);
    bank_load_i <= 0; fast_select_i <= 1;
    @(negedge ref_clk_i);
    `CHK("restore_off", 1'b0, restore_valid_o)
    `CHK("bank_new", 4'h9, ram_bank_pointer_o)
    @(posedge ref_clk_i);
    fast_restore_i <= 0;
    @(negedge ref_clk_i);
    `CHK("restore_v", 1'b1, restore_valid_o)
    `CHK("restore_w", 8'ha5, restore_wreg_o)
    `CHK("restore_s", 8'h3c, restore_status_o)
    `CHK("bank_back", 4'h5, ram_bank_pointer_o)
    @(negedge ref_clk_i);
    `CHK("restore_end", 1'b0, restore_valid_o)
  endtask

  initial
  begin
    exp_pc = PC_RESET;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 0;
    @(negedge ref_clk_i);
    `CHK("pc_reset", PC_RESET, pc_o)
    test_clears();
    test_branches();
    test_shadow_and_ptrs();
    print_verdict();
  end
endmodule
